// ---- atc_cfg_regs.vh ----
`ifndef ATC_CFG_REGS_VH
`define ATC_CFG_REGS_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define ATC_ADDR_GAIN_HI     7'h00
`define ATC_ADDR_GAIN_LO     7'h01
`define ATC_ADDR_COARSE      7'h02
`define ATC_ADDR_FINE        7'h03
`define ATC_ADDR_OFFSET_LO   7'h04
`define ATC_ADDR_LAST        7'h04

// ----------------------------------------
// field positions
// ----------------------------------------
`define ATC_GAIN_LO_MSB      7
`define ATC_GAIN_LO_LSB      4
`define ATC_FOUR_WIRE_BIT    3
`define ATC_SOFT_RST_BIT     2
`define ATC_SINGLE_BUS_BIT   0
`define ATC_CLK_DIV2_BIT     1
`define ATC_COARSE_MSB       7
`define ATC_COARSE_LSB       3
`define ATC_FINE_MSB         7
`define ATC_FINE_LSB         2
`define ATC_OFFSET_MSB_BIT   0

// ----------------------------------------
// reset values
// ----------------------------------------
`define ATC_RST_GAIN         12'h000
`define ATC_RST_COARSE       5'h00
`define ATC_RST_FINE         6'h00
`define ATC_RST_MODE_BIT     1'b0
`define ATC_RST_BYTE         8'h00

// ----------------------------------------
// serial frame: read flag, 7 address bits, 8 data bits
// ----------------------------------------
`define ATC_HDR_BITS         4'h8
`define ATC_DATA_BITS        4'h8

`endif

// ---- atc_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module atc_host_model (
	// clock
	input wire logic  core_clk,
	// lines seen by the host
	input wire logic  sdio_wire,
	input wire logic  read_line,
	// lines driven by the host
	output var logic  sclk,
	output var logic  sen_n,
	output var logic  sdio_drv
);
	initial begin
		sclk = 1'b0;
		sen_n = 1'b1;
		sdio_drv = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// nb below 16 aborts the frame early
	task automatic frame(input logic rd, input logic [6:0] a, input logic [7:0] d,
			input logic four, input int nb, output logic [7:0] q);
		logic [15:0] w;
		w = {rd, a, d};
		q = 8'h00;
		sen_n = 1'b0;
		for (int i = 0; i < nb; i++) begin
			tick(4);
			sclk = 1'b0;
			// released pin shows no stale bit
			sdio_drv = (rd && i > 7) ? ~sdio_drv : w[15 - i];
			tick(4);
			if (i > 7) q = {q[6:0], four ? read_line : sdio_wire};
			sclk = 1'b1;
		end
		tick(4);
		sclk = 1'b0;
		tick(4);
		sen_n = 1'b1;
		tick(8);
	endtask
endmodule
`default_nettype wire

// ---- atc_sync.v ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// two-flop synchroniser, one chain per bit
// ----------------------------------------
module atc_sync #(
	parameter WIDTH = 1
) (
	// clock and reset
	input  wire             clk,
	input  wire             rst,
	// asynchronous in, synchronous out
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg meta;
			reg stable;
			// meta feeds only the second flop
			always @(posedge clk) begin
				if (rst) begin
					meta   <= 1'b0;
					stable <= 1'b0;
				end else begin
					meta   <= async_in[i];
					stable <= meta;
				end
			end
			assign sync_out[i] = stable;
		end
	endgenerate

endmodule

`default_nettype wire

// ---- atc_trim_bank.v ----
`timescale 1ns/1ps
`default_nettype none

`include "atc_cfg_regs.vh"

module atc_trim_bank (
	// clock and reset
	input  wire        CORE_CLK,
	input  wire        SYS_RST,
	// serial port pins
	input  wire        SPI_SCLK,
	input  wire        SPI_SEN_N,
	input  wire        SPI_SDIO_IN,
	output wire        SPI_SDIO_OUT,
	output wire        SPI_SDIO_OE,
	output wire        SERIAL_READ_LINE,
	output wire        SERIAL_READ_LINE_OE,
	// per-part offset trim value
	input  wire [8:0]  OFFSET_TRIM_DEFAULT,
	// trims into the converter core
	output wire [11:0] GAIN_TRIM,
	output wire [4:0]  COARSE_PHASE,
	output wire [5:0]  FINE_PHASE,
	output wire [8:0]  OFFSET_TRIM,
	// output logic modes
	output wire        FOUR_WIRE_MODE,
	output wire        SINGLE_BUS,
	output wire        OUTPUT_CLOCK_DIV2
);

	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam [3:0] ST_HDR   = 4'h1;
	localparam [3:0] ST_WDATA = 4'h2;
	localparam [3:0] ST_RDATA = 4'h4;
	localparam [3:0] ST_DONE  = 4'h8;

	// ----------------------------------------
	// pin synchronisation
	// ----------------------------------------
	wire [2:0] pins_s;
	wire       sclk_s;
	wire       sen_n_s;
	wire       sdio_s;

	atc_sync #(
		.WIDTH (3)
	) u_sync (
		.clk      (CORE_CLK),
		.rst      (SYS_RST),
		.async_in ({SPI_SCLK, SPI_SEN_N, SPI_SDIO_IN}),
		.sync_out (pins_s)
	);

	assign sclk_s  = pins_s[2];
	assign sen_n_s = pins_s[1];
	assign sdio_s  = pins_s[0];

	reg        sclk_d;
	wire       sclk_rise;
	wire       sclk_fall;

	always @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			sclk_d <= 1'b0;
		end else begin
			sclk_d <= sclk_s;
		end
	end

	assign sclk_rise = sclk_s & ~sclk_d;
	assign sclk_fall = ~sclk_s & sclk_d;

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	reg [11:0] gain;
	reg        four_wire;
	reg        single_bus;
	reg        clk_div2;
	reg [4:0]  coarse;
	reg [5:0]  fine;
	reg [8:0]  offset;

	function addr_valid;
		input [6:0] a;
		begin
			addr_valid = (a <= `ATC_ADDR_LAST);
		end
	endfunction

	// reserved bits are not stored, so they always read back as zero
	function [7:0] rd_byte;
		input [6:0] a;
		begin
			rd_byte = `ATC_RST_BYTE;
			case (a)
				`ATC_ADDR_GAIN_HI:   rd_byte = gain[11:4];
				`ATC_ADDR_GAIN_LO:   rd_byte = {gain[3:0], four_wire, 3'h0};
				`ATC_ADDR_COARSE:    rd_byte = {coarse, 1'b0, clk_div2, single_bus};
				`ATC_ADDR_FINE:      rd_byte = {fine, 1'b0, offset[8]};
				`ATC_ADDR_OFFSET_LO: rd_byte = offset[7:0];
				default:             rd_byte = `ATC_RST_BYTE;
			endcase
		end
	endfunction

	// ----------------------------------------
	// serial frame engine
	// ----------------------------------------
	reg [3:0] state;
	reg [3:0] bit_cnt;
	reg [6:0] shift_in;
	reg [6:0] addr;
	reg [7:0] tx;
	reg       wr_stb;
	reg [7:0] wr_data;

	wire [7:0] in_byte;
	assign in_byte = {shift_in, sdio_s};

	always @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			state    <= ST_HDR;
			bit_cnt  <= 4'h0;
			shift_in <= 7'h00;
			addr     <= 7'h00;
			tx       <= `ATC_RST_BYTE;
			wr_stb   <= 1'b0;
			wr_data  <= `ATC_RST_BYTE;
		end else if (sen_n_s) begin
			// deselect aborts any half frame, nothing is written
			state   <= ST_HDR;
			bit_cnt <= 4'h0;
			wr_stb  <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			case (state)
				ST_HDR: begin
					if (sclk_rise) begin
						shift_in <= in_byte[6:0];
						bit_cnt  <= bit_cnt + 4'h1;
						if (bit_cnt == `ATC_HDR_BITS - 4'h1) begin
							bit_cnt <= 4'h0;
							addr    <= in_byte[6:0];
							if (in_byte[7]) begin
								state <= ST_RDATA;
								tx    <= rd_byte(in_byte[6:0]);
							end else begin
								state <= ST_WDATA;
							end
						end
					end
				end
				ST_WDATA: begin
					if (sclk_rise) begin
						shift_in <= in_byte[6:0];
						bit_cnt  <= bit_cnt + 4'h1;
						if (bit_cnt == `ATC_DATA_BITS - 4'h1) begin
							wr_stb  <= 1'b1;
							wr_data <= in_byte;
							state   <= ST_DONE;
						end
					end
				end
				ST_RDATA: begin
					// first bit already stands on the line before the first fall
					if (sclk_fall && bit_cnt != 4'h0) begin
						tx <= {tx[6:0], 1'b0};
					end
					if (sclk_rise) begin
						bit_cnt <= bit_cnt + 4'h1;
						if (bit_cnt == `ATC_DATA_BITS - 4'h1) begin
							state <= ST_DONE;
						end
					end
				end
				ST_DONE: begin
					state <= ST_DONE;
				end
				default: begin
					state <= ST_HDR;
				end
			endcase
		end
	end

	// ----------------------------------------
	// readback drivers
	// ----------------------------------------
	wire rd_drive;
	assign rd_drive = (state == ST_RDATA) & ~sen_n_s;

	assign SPI_SDIO_OUT        = tx[7];
	assign SPI_SDIO_OE         = rd_drive & ~four_wire;
	assign SERIAL_READ_LINE    = tx[7];
	assign SERIAL_READ_LINE_OE = rd_drive & four_wire;

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	wire soft_rst;
	assign soft_rst = wr_stb & (addr == `ATC_ADDR_GAIN_LO) & wr_data[`ATC_SOFT_RST_BIT];

	// soft reset discards the rest of the written byte; the bit is never stored
	always @(posedge CORE_CLK) begin
		if (SYS_RST || soft_rst) begin
			gain       <= `ATC_RST_GAIN;
			four_wire  <= `ATC_RST_MODE_BIT;
			single_bus <= `ATC_RST_MODE_BIT;
			clk_div2   <= `ATC_RST_MODE_BIT;
			coarse     <= `ATC_RST_COARSE;
			fine       <= `ATC_RST_FINE;
			offset     <= OFFSET_TRIM_DEFAULT;
		end else if (wr_stb && addr_valid(addr)) begin
			case (addr)
				`ATC_ADDR_GAIN_HI: begin
					gain[11:4] <= wr_data;
				end
				`ATC_ADDR_GAIN_LO: begin
					gain[3:0] <= wr_data[`ATC_GAIN_LO_MSB:`ATC_GAIN_LO_LSB];
					four_wire <= wr_data[`ATC_FOUR_WIRE_BIT];
				end
				`ATC_ADDR_COARSE: begin
					coarse     <= wr_data[`ATC_COARSE_MSB:`ATC_COARSE_LSB];
					clk_div2   <= wr_data[`ATC_CLK_DIV2_BIT];
					single_bus <= wr_data[`ATC_SINGLE_BUS_BIT];
				end
				`ATC_ADDR_FINE: begin
					fine      <= wr_data[`ATC_FINE_MSB:`ATC_FINE_LSB];
					offset[8] <= wr_data[`ATC_OFFSET_MSB_BIT];
				end
				`ATC_ADDR_OFFSET_LO: begin
					offset[7:0] <= wr_data;
				end
				default: begin
					gain <= gain;
				end
			endcase
		end
	end

	// ----------------------------------------
	// outputs to core
	// ----------------------------------------
	// codes pass straight through; analogue scaling lives in the core
	assign GAIN_TRIM      = gain;
	assign COARSE_PHASE   = coarse;
	assign FINE_PHASE     = fine;
	assign OFFSET_TRIM    = offset;
	assign FOUR_WIRE_MODE = four_wire;
	assign SINGLE_BUS     = single_bus;
	// divide-by-4 cannot serve a single bus, so that pairing falls back to 2
	assign OUTPUT_CLOCK_DIV2 = clk_div2 | single_bus;

endmodule

`default_nettype wire

// ---- atc_trim_bank_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module atc_trim_bank_monitor (
	// clock and reset
	input wire logic        CORE_CLK,
	input wire logic        SYS_RST,
	// serial port
	input wire logic        SPI_SEN_N,
	input wire logic        SPI_SDIO_OE,
	input wire logic        SERIAL_READ_LINE_OE,
	// trims and modes
	input wire logic [8:0]  OFFSET_TRIM_DEFAULT,
	input wire logic [11:0] GAIN_TRIM,
	input wire logic [4:0]  COARSE_PHASE,
	input wire logic [5:0]  FINE_PHASE,
	input wire logic [8:0]  OFFSET_TRIM,
	input wire logic        FOUR_WIRE_MODE,
	input wire logic        SINGLE_BUS,
	input wire logic        OUTPUT_CLOCK_DIV2
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);
	AST_OE_EXCL: assert property (!(SPI_SDIO_OE && SERIAL_READ_LINE_OE))
		else $error("both read drivers on");
	AST_OE_3W: assert property (SPI_SDIO_OE |-> !FOUR_WIRE_MODE)
		else $error("data pin driven in 4-wire mode");
	AST_OE_4W: assert property (SERIAL_READ_LINE_OE |-> FOUR_WIRE_MODE)
		else $error("read line driven in 3-wire mode");
	AST_IDLE_OE: assert property (SPI_SEN_N [*4] |-> !SPI_SDIO_OE && !SERIAL_READ_LINE_OE)
		else $error("read driver on while deselected");
	AST_DIV: assert property (SINGLE_BUS |-> OUTPUT_CLOCK_DIV2)
		else $error("divide by 4 with single bus");
	AST_RST: assert property (disable iff (1'b0) SYS_RST |=> GAIN_TRIM == 12'h000
		&& {COARSE_PHASE, FINE_PHASE} == 11'h000 && OFFSET_TRIM == OFFSET_TRIM_DEFAULT)
		else $error("reset values wrong");
	AST_HOLD: assert property (SPI_SEN_N [*6] |=> $stable({GAIN_TRIM, OFFSET_TRIM}))
		else $error("trim changed outside a frame");
	AST_MODE_HOLD: assert property (SPI_SEN_N [*6] |=> $stable({FOUR_WIRE_MODE,
		SINGLE_BUS, COARSE_PHASE, FINE_PHASE})) else $error("mode changed outside a frame");
	cover property (SPI_SDIO_OE);
	cover property (SERIAL_READ_LINE_OE);
	cover property ($rose(SINGLE_BUS));
endmodule
`default_nettype wire

// ---- atc_trim_bank_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module atc_trim_bank_tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        sclk, sen_n, sdrv;
	logic [8:0]  dflt = 9'h000;
	wire         sd_out, sd_oe, rl, rl_oe, four, single, div2;
	wire  [11:0] gain;
	wire  [4:0]  coarse;
	wire  [5:0]  fine;
	wire  [8:0]  ofs;
	wire         sdio = sd_oe ? sd_out : sdrv;
	logic [7:0]  m [0:4];
	logic [7:0]  q;
	logic [7:0]  mask [0:4] = '{8'hFF, 8'hF8, 8'hFB, 8'hFD, 8'hFF};
	logic [7:0]  cor [0:4] = '{8'hFF, 8'hF8, 8'hFB, 8'hFD, 8'hFF};
	int          bad_count = 0;
	int          n_tests = 0;
	int          seed = 71930;
	always #25 clk = ~clk;
	atc_trim_bank DUT (.CORE_CLK(clk), .SYS_RST(rst), .SPI_SCLK(sclk), .SPI_SEN_N(sen_n),
		.SPI_SDIO_IN(sdio), .SPI_SDIO_OUT(sd_out), .SPI_SDIO_OE(sd_oe), .SERIAL_READ_LINE(rl),
		.SERIAL_READ_LINE_OE(rl_oe), .OFFSET_TRIM_DEFAULT(dflt), .GAIN_TRIM(gain),
		.COARSE_PHASE(coarse), .FINE_PHASE(fine), .OFFSET_TRIM(ofs), .FOUR_WIRE_MODE(four),
		.SINGLE_BUS(single), .OUTPUT_CLOCK_DIV2(div2));
	atc_host_model host (.core_clk(clk), .sdio_wire(sdio), .read_line(rl_oe ? rl : ~rl),
		.sclk(sclk), .sen_n(sen_n), .sdio_drv(sdrv));
	task automatic chk(input logic [11:0] g, input logic [11:0] e, input string s);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %0t %s got %h exp %h", $time, s, g, e);
		end
	endtask
	function automatic void set_dflt;
		for (int i = 0; i < 3; i++) m[i] = 8'h00;
		m[3] = {7'h00, dflt[8]};
		m[4] = dflt[7:0];
	endfunction
	task automatic chk_out;
		chk(gain, {m[0], m[1][7:4]}, "gain");
		chk({7'h00, coarse}, {7'h00, m[2][7:3]}, "coarse");
		chk({6'h00, fine}, {6'h00, m[3][7:2]}, "fine");
		chk({3'h0, ofs}, {3'h0, m[3][0], m[4]}, "offset");
		chk({9'h000, four, single, div2}, {9'h000, m[1][3], m[2][0], m[2][1] | m[2][0]}, "modes");
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host.frame(1'b0, a, d, m[1][3], 16, q);
	endtask
	task automatic rd_all;
		for (int a = 0; a < 5; a++) begin
			host.frame(1'b1, a[6:0], 8'h00, m[1][3], 16, q);
			chk({4'h0, q}, {4'h0, m[a]}, "readback");
		end
	endtask
	task automatic tally_and_finish;
		$display("%0d checks, %0d mismatches", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#2000000;
		bad_count++;
		tally_and_finish;
	end
	initial begin
		logic [2:0] a;
		dflt = 9'($random(seed));
		repeat (10) @(posedge clk);
		#1 rst = 1'b0;
		set_dflt;
		chk_out;
		rd_all;
		$display("reset test done");
		// corners first, then random bytes with reserved bits kept at zero
		for (int i = 0; i < 17; i++) begin
			a = (i < 5) ? 3'(i) : 3'({$random(seed)} % 5);
			m[a] = (i < 5) ? cor[i] : 8'($random(seed)) & mask[a];
			// single bus is never paired with divide-by-4
			if (a == 3'h2 && m[a][0]) m[a][1] = 1'b1;
			wr({4'h0, a}, m[a]);
			chk_out;
			if (i == 4 || i == 16) rd_all;
		end
		$display("write test done");
		wr(7'h05, 8'hA5);
		wr(7'h7F, 8'h5A);
		chk_out;
		host.frame(1'b1, 7'h7F, 8'h00, m[1][3], 16, q);
		chk({4'h0, q}, 12'h000, "unmapped");
		host.frame(1'b0, 7'h00, ~m[0], m[1][3], 12, q);
		chk_out;
		$display("unmapped and abort test done");
		dflt = 9'($random(seed));
		wr(7'h01, 8'hFC);
		set_dflt;
		chk_out;
		rd_all;
		$display("soft reset test done");
		tally_and_finish;
	end
endmodule
bind atc_trim_bank atc_trim_bank_monitor mon (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
	.SPI_SEN_N(SPI_SEN_N), .SPI_SDIO_OE(SPI_SDIO_OE), .SERIAL_READ_LINE_OE(SERIAL_READ_LINE_OE),
	.OFFSET_TRIM_DEFAULT(OFFSET_TRIM_DEFAULT), .GAIN_TRIM(GAIN_TRIM),
	.COARSE_PHASE(COARSE_PHASE), .FINE_PHASE(FINE_PHASE), .OFFSET_TRIM(OFFSET_TRIM),
	.FOUR_WIRE_MODE(FOUR_WIRE_MODE), .SINGLE_BUS(SINGLE_BUS),
	.OUTPUT_CLOCK_DIV2(OUTPUT_CLOCK_DIV2));
`default_nettype wire
